/* flash_status_consts.svh */
// constants for the serial flash status register bank
`ifndef FLASH_STATUS_CONSTS_SVH
`define FLASH_STATUS_CONSTS_SVH

// ==========================================================
// instruction codes
`define OP_WRITE_ENABLE 8'h06
`define OP_WRITE_DISABLE 8'h04
`define OP_READ_LOW 8'h05
`define OP_READ_MID 8'h35
`define OP_READ_HIGH 8'h15
`define OP_WRITE_LOW 8'h01
`define OP_WRITE_MID 8'h31
`define OP_WRITE_HIGH 8'h11
`define OP_PAGE_PROGRAM 8'h02
`define OP_SECTOR_ERASE 8'h20
`define OP_BLOCK_ERASE 8'hd8
`define OP_ERASE_SUSPEND 8'h75
`define OP_ERASE_RESUME 8'h7a
`define OP_ENTER_FOUR_WIRE 8'h38
`define OP_EXIT_FOUR_WIRE 8'hff

// ==========================================================
// frame lengths in serial clock edges
`define FRAME_OP_BITS 6'h08
`define FRAME_DATA_BITS 6'h10
`define FRAME_ADDR_BITS 6'h20
`define FRAME_BITS_MAX 6'h3f

// ==========================================================
// reset values and writable masks
`define LOW_RESET 8'h00
`define MID_RESET 8'h00
`define HIGH_RESET 8'h40
`define LOW_WR_MASK 8'hfc
`define MID_WR_MASK 8'h7f
`define HIGH_WR_MASK 8'he4
`define MID_LOCK_MASK 8'h3c
`define MID_QUAD_BIT 1

// ==========================================================
// protection geometry
`define ARRAY_ADDR_BITS 24
`define SECTOR_SHIFT 12
`define BLOCK_SHIFT 17
`define SECTOR_SHIFT_CAP 3'h4

// ==========================================================
// timing
`define CLK_PERIOD_NS 10
`define STATUS_WRITE_NS 1000
`define PROGRAM_NS 2000
`define ERASE_NS 4000
`define STATUS_WRITE_CYCLES ((`STATUS_WRITE_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
`define PROGRAM_CYCLES ((`PROGRAM_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
`define ERASE_CYCLES ((`ERASE_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)

`endif

/* flash_status_pkg.sv */
// types for the serial flash status register bank
package flash_status_pkg;

  // ========================================================
  // lowest status register
  typedef struct packed {
    logic guard_mode_low;
    logic small_unit_select;
    logic bottom_up_select;
    logic protect_size_bit2;
    logic protect_size_bit1;
    logic protect_size_bit0;
    logic write_latch_flag;
    logic write_busy_flag;
  } status_low_t;

  // ========================================================
  // middle status register
  typedef struct packed {
    logic erase_paused_flag;
    logic invert_protection;
    logic otp_lock_three;
    logic otp_lock_two;
    logic otp_lock_one;
    logic otp_lock_zero;
    logic quad_io_enable;
    logic guard_mode_high;
  } status_mid_t;

  // ========================================================
  // highest status register
  typedef struct packed {
    logic pause_reset_select;
    logic drive_strength_high;
    logic drive_strength_low;
    logic [1:0] spare_hi;
    logic protect_scheme_select;
    logic [1:0] spare_lo;
  } status_high_t;

  // ========================================================
  // whole bank and embedded operation state
  typedef struct packed {
    status_high_t high;
    status_mid_t mid;
    status_low_t low;
  } status_bank_t;

  typedef enum logic [1:0] {
    OP_IDLE = 2'b00,
    OP_BUSY = 2'b01,
    OP_PAUSED = 2'b11
  } op_state_t;

endpackage

/* serial_flash_status_regs.sv */
// status and configuration register bank of a serial flash
`timescale 1ns/10ps
`include "flash_status_consts.svh"

module serial_flash_status_regs
  import flash_status_pkg::*;
(
  // system
  input wire logic clk,
  input wire logic rst_b,
  input wire logic factory_b,
  // serial link
  input wire logic sclk,
  input wire logic cs_b,
  input wire logic si,
  output logic so,
  output logic so_oe_b,
  // guard pins
  input wire logic wp_b,
  // configuration seen by the rest of the device
  output logic [1:0] drive_strength,
  output logic hold_fn_active,
  output logic reset_fn_active,
  output logic wp_fn_active,
  output logic four_wire_command_mode,
  output logic write_busy
);

  // ========================================================
  // link side: shift in bits, count edges
  logic [5:0] bit_cnt;
  logic [5:0] frame_bits;
  logic [31:0] shreg;
  logic rd_on;
  logic [7:0] rd_shift;
  logic [7:0] rd_byte;
  status_bank_t shadow;

  // edge counter, cleared while deselected
  always_ff @(posedge sclk or posedge cs_b)
  begin
    if (cs_b)
      bit_cnt <= 6'h00;
    else if (bit_cnt != `FRAME_BITS_MAX)
      bit_cnt <= bit_cnt + 6'h01;
  end

  // shift register and frame length, held after the frame
  always_ff @(posedge sclk)
  begin
    if (bit_cnt < `FRAME_ADDR_BITS)
      shreg <= {shreg[30:0], si};
    if (bit_cnt != `FRAME_BITS_MAX)
      frame_bits <= bit_cnt + 6'h01;
  end

  function automatic logic is_read(input logic [7:0] op);
    is_read = (op == `OP_READ_LOW) || (op == `OP_READ_MID) || (op == `OP_READ_HIGH);
  endfunction

  function automatic logic [7:0] pick_byte(input logic [7:0] op, input status_bank_t b);
    if (op == `OP_READ_MID)
      pick_byte = b.mid;
    else if (op == `OP_READ_HIGH)
      pick_byte = b.high;
    else
      pick_byte = b.low;
  endfunction
  // byte picked by the opcode from the snapshot frozen during the frame
  assign rd_byte = pick_byte(shreg[7:0], shadow);

  // read data leaves on the falling edge, byte repeats
  always_ff @(negedge sclk or posedge cs_b)
  begin
    if (cs_b)
    begin
      rd_on <= 1'b0;
      so_oe_b <= 1'b1;
      so <= 1'b0;
      rd_shift <= 8'h00;
    end
    else if (bit_cnt == `FRAME_OP_BITS && is_read(shreg[7:0]))
    begin
      rd_on <= 1'b1;
      so_oe_b <= 1'b0;
      so <= rd_byte[7];
      rd_shift <= {rd_byte[6:0], rd_byte[7]};
    end
    else if (rd_on)
    begin
      so <= rd_shift[7];
      rd_shift <= {rd_shift[6:0], rd_shift[7]};
    end
  end

  // ========================================================
  // pin synchronisers
  logic cs_s1, cs_s2, cs_s3;
  logic wp_s1, wp_s2;
  logic frame_end;

  always_ff @(posedge clk)
  begin
    if (!rst_b)
    begin
      cs_s1 <= 1'b1;
      cs_s2 <= 1'b1;
      cs_s3 <= 1'b1;
      wp_s1 <= 1'b1;
      wp_s2 <= 1'b1;
    end
    else
    begin
      cs_s1 <= cs_b;
      cs_s2 <= cs_s1;
      cs_s3 <= cs_s2;
      wp_s1 <= wp_b;
      wp_s2 <= wp_s1;
    end
  end

  assign frame_end = cs_s2 && !cs_s3;

  // ========================================================
  // frame decode
  logic [7:0] op;
  logic [7:0] wdata;
  logic [23:0] addr;
  logic has_data, has_addr;

  always_comb
  begin
    op = 8'h00;
    wdata = 8'h00;
    addr = shreg[23:0];
    has_data = 1'b0;
    has_addr = 1'b0;
    if (frame_bits == `FRAME_OP_BITS)
      op = shreg[7:0];
    else if (frame_bits == `FRAME_DATA_BITS)
    begin
      op = shreg[15:8];
      wdata = shreg[7:0];
      has_data = 1'b1;
    end
    else if (frame_bits >= `FRAME_ADDR_BITS)
    begin
      op = shreg[31:24];
      has_addr = 1'b1;
    end
  end

  // ========================================================
  // register bank and protection
  status_low_t sr_low;
  status_mid_t sr_mid;
  status_high_t sr_high;
  logic busy_flag, latch_flag, paused_flag;
  logic [5:0] low_cfg;
  logic [6:0] mid_cfg;
  op_state_t state;
  logic [15:0] timer;
  logic op_is_erase;
  // low register is its kept configuration bits over its two volatile flags, middle is its paused flag over its kept bits
  assign sr_low = {low_cfg, latch_flag, busy_flag};
  assign sr_mid = {paused_flag, mid_cfg};

  // status write guard from the two mode bits, the pin and the quad enable bit
  logic sr_locked;
  assign sr_locked = sr_mid.guard_mode_high ||
                     (sr_low.guard_mode_low && !wp_s2 && !sr_mid.quad_io_enable);

  // address falls in a protected region
  function automatic logic addr_protected(input logic [23:0] a, input status_low_t l,
                                          input status_mid_t m, input status_high_t h);
    logic [2:0] size;
    logic [4:0] shift;
    logic [24:0] span;
    logic in_region;
    size = {l.protect_size_bit2, l.protect_size_bit1, l.protect_size_bit0};
    shift = 5'h00;
    span = 25'h0000000;
    in_region = 1'b0;
    if (l.small_unit_select)
      shift = 5'(`SECTOR_SHIFT) + 5'((size > `SECTOR_SHIFT_CAP) ? 3'h3 : size - 3'h1);
    else
      shift = 5'(`BLOCK_SHIFT) + 5'(size);
    span = 25'h0000001 << shift;
    if (size == 3'h7)
      in_region = 1'b1;
    else if (size == 3'h0)
      in_region = 1'b0;
    else if (l.bottom_up_select)
      in_region = {1'b0, a} < span;
    else
      in_region = {1'b0, a} >= (25'h1000000 - span);
    if (h.protect_scheme_select)
      addr_protected = 1'b1;
    else
      addr_protected = in_region ^ m.invert_protection;
  endfunction

  logic can_write, sr_write, prog_ok, erase_ok;
  assign can_write = sr_low.write_latch_flag && (state == OP_IDLE);
  assign sr_write = frame_end && has_data && can_write && !sr_locked &&
                    (op == `OP_WRITE_LOW || op == `OP_WRITE_MID || op == `OP_WRITE_HIGH);
  assign prog_ok = frame_end && has_addr && can_write && (op == `OP_PAGE_PROGRAM) &&
                   !addr_protected(addr, sr_low, sr_mid, sr_high);
  assign erase_ok = frame_end && has_addr && can_write &&
                    (op == `OP_SECTOR_ERASE || op == `OP_BLOCK_ERASE) &&
                    !addr_protected(addr, sr_low, sr_mid, sr_high);

  // embedded operation timer and state
  always_ff @(posedge clk)
  begin
    if (!rst_b)
    begin
      state <= OP_IDLE;
      timer <= 16'h0000;
      op_is_erase <= 1'b0;
    end
    else
    begin
      unique case (state)
        OP_IDLE:
        begin
          if (sr_write || prog_ok || erase_ok)
          begin
            state <= OP_BUSY;
            op_is_erase <= erase_ok;
            timer <= erase_ok ? 16'(`ERASE_CYCLES) :
                     prog_ok ? 16'(`PROGRAM_CYCLES) : 16'(`STATUS_WRITE_CYCLES);
          end
        end
        OP_BUSY:
        begin
          if (frame_end && op == `OP_ERASE_SUSPEND && op_is_erase)
            state <= OP_PAUSED;
          else if (timer == 16'h0001)
          begin
            state <= OP_IDLE;
            timer <= 16'h0000;
          end
          else
            timer <= timer - 16'h0001;
        end
        OP_PAUSED:
        begin
          if (frame_end && op == `OP_ERASE_RESUME)
            state <= OP_BUSY;
        end
        default:
          state <= OP_IDLE;
      endcase
    end
  end

  // volatile flags follow the operation state
  always_ff @(posedge clk)
  begin
    if (!rst_b)
    begin
      busy_flag <= 1'b0;
      latch_flag <= 1'b0;
      paused_flag <= 1'b0;
    end
    else
    begin
      busy_flag <= (state == OP_BUSY) ? (timer != 16'h0001 && // suspend drops busy
                   !(frame_end && op == `OP_ERASE_SUSPEND && op_is_erase)) :
                   (sr_write || prog_ok || erase_ok ||
                    (state == OP_PAUSED && frame_end && op == `OP_ERASE_RESUME));
      if (state == OP_BUSY && timer == 16'h0001 &&
          !(frame_end && op == `OP_ERASE_SUSPEND && op_is_erase))
        latch_flag <= 1'b0;
      else if (frame_end && op == `OP_WRITE_ENABLE && state == OP_IDLE)
        latch_flag <= 1'b1;
      else if (frame_end && op == `OP_WRITE_DISABLE && state == OP_IDLE)
        latch_flag <= 1'b0;
      if (state == OP_BUSY && frame_end && op == `OP_ERASE_SUSPEND && op_is_erase)
        paused_flag <= 1'b1;
      else if (state == OP_PAUSED && frame_end && op == `OP_ERASE_RESUME)
        paused_flag <= 1'b0;
    end
  end

  // configuration bits kept across power cycles, defaults on factory init
  always_ff @(posedge clk)
  begin
    if (!factory_b)
    begin
      low_cfg <= 6'(`LOW_RESET >> 2);
      mid_cfg <= 7'(`MID_RESET);
      sr_high <= `HIGH_RESET;
    end
    else if (!rst_b)
    begin
      if (sr_mid.guard_mode_high && !sr_low.guard_mode_low)
        mid_cfg[0] <= 1'b0; // supply lock-down ends with power
    end
    else if (sr_write)
    begin
      if (op == `OP_WRITE_LOW)
        low_cfg <= wdata[7:2] & 6'(`LOW_WR_MASK >> 2);
      else if (op == `OP_WRITE_MID)
      begin
        mid_cfg[6] <= wdata[6];
        mid_cfg[0] <= wdata[0];
        mid_cfg[5:2] <= mid_cfg[5:2] | wdata[5:2];
        mid_cfg[`MID_QUAD_BIT] <= wdata[`MID_QUAD_BIT] || four_wire_command_mode;
      end
      else
        sr_high <= wdata & `HIGH_WR_MASK;
    end
  end

  // four-wire command mode entry and exit
  always_ff @(posedge clk)
  begin
    if (!rst_b)
      four_wire_command_mode <= 1'b0;
    else if (frame_end && op == `OP_ENTER_FOUR_WIRE && sr_mid.quad_io_enable)
      four_wire_command_mode <= 1'b1;
    else if (frame_end && op == `OP_EXIT_FOUR_WIRE)
      four_wire_command_mode <= 1'b0;
  end

  // snapshot for the link, frozen while a frame runs
  always_ff @(posedge clk)
  begin
    if (!rst_b)
      shadow <= {`HIGH_RESET, `MID_RESET, `LOW_RESET};
    else if (cs_s2)
      shadow <= {sr_high, sr_mid, sr_low};
  end

  // pin functions and drive strength
  always_ff @(posedge clk)
  begin
    if (!rst_b)
    begin
      drive_strength <= 2'h2;
      hold_fn_active <= 1'b0;
      reset_fn_active <= 1'b0;
      wp_fn_active <= 1'b0;
      write_busy <= 1'b0;
    end
    else
    begin
      drive_strength <= {sr_high.drive_strength_high, sr_high.drive_strength_low};
      hold_fn_active <= !sr_mid.quad_io_enable && !sr_high.pause_reset_select;
      reset_fn_active <= !sr_mid.quad_io_enable && sr_high.pause_reset_select;
      wp_fn_active <= !sr_mid.quad_io_enable;
      write_busy <= sr_low.write_busy_flag;
    end
  end

  // ========================================================
  // checks
  chk_busy_follows_op: assert property (@(posedge clk) disable iff (!rst_b)
    1'b1 |=> sr_low.write_busy_flag == ($past(state) != OP_IDLE ? state == OP_BUSY :
             state == OP_BUSY))
    else $error("busy flag does not follow the operation state");
  chk_no_latch_reject: assert property (@(posedge clk) disable iff (!rst_b)
    frame_end && !sr_low.write_latch_flag |=> state == $past(state) || $past(state) != OP_IDLE)
    else $error("operation started without the write latch");
  chk_volatile_reset: assert property (@(posedge clk)
    !rst_b |=> !sr_low.write_busy_flag && !sr_low.write_latch_flag &&
               !sr_mid.erase_paused_flag && state == OP_IDLE)
    else $error("volatile flags not cleared by reset");
  chk_guard_holds: assert property (@(posedge clk) disable iff (!rst_b || !factory_b)
    frame_end && sr_locked |=> $stable(sr_low[7:2]) && $stable(sr_mid[6:0]))
    else $error("guarded status register changed");
  chk_four_wire_gate: assert property (@(posedge clk) disable iff (!rst_b)
    frame_end && op == `OP_ENTER_FOUR_WIRE && !sr_mid.quad_io_enable &&
    !four_wire_command_mode |=> !four_wire_command_mode)
    else $error("four-wire mode entered without quad enable");
  chk_four_wire_quad: assert property (@(posedge clk) disable iff (!rst_b || !factory_b)
    four_wire_command_mode |-> sr_mid.quad_io_enable)
    else $error("quad enable dropped in four-wire mode");
  chk_lock_sticky: assert property (@(posedge clk) disable iff (!factory_b)
    ($past(sr_mid[5:2]) & ~sr_mid[5:2]) == 4'h0)
    else $error("lock bit cleared");
  chk_suspend_pauses: assert property (@(posedge clk) disable iff (!rst_b)
    state == OP_BUSY && frame_end && op == `OP_ERASE_SUSPEND && op_is_erase
    |=> sr_mid.erase_paused_flag && !sr_low.write_busy_flag)
    else $error("erase suspend did not set the paused flag");
  chk_op_completes: assert property (@(posedge clk) disable iff (!rst_b)
    state == OP_BUSY && timer == 16'h0001 && !frame_end
    |=> !sr_low.write_busy_flag && !sr_low.write_latch_flag ##1 !write_busy)
    else $error("operation end did not clear busy and latch");
  chk_pin_function: assert property (@(posedge clk) disable iff (!rst_b)
    1'b1 |=> hold_fn_active == $past(!sr_mid.quad_io_enable && !sr_high.pause_reset_select))
    else $error("pause pin function wrong for quad setting");
  cov_status_write: cover property (@(posedge clk) disable iff (!rst_b) sr_write);
  cov_erase_paused: cover property (@(posedge clk) disable iff (!rst_b) state == OP_PAUSED);
  cov_four_wire: cover property (@(posedge clk) disable iff (!rst_b) four_wire_command_mode);
  cov_prog_refused: cover property (@(posedge clk) disable iff (!rst_b)
    frame_end && has_addr && op == `OP_PAGE_PROGRAM && can_write && !prog_ok);

endmodule

/* flash_host_model.sv */
// serial host model that drives framed transfers on the flash link
`timescale 1ns/10ps

module flash_host_model
(
  // link pins
  output logic sclk,
  output logic cs_b,
  output logic si,
  input wire logic so,
  input wire logic so_oe_b
);

  // ==========================================================
  // idle levels: clock parked low between frames, device deselected
  initial
  begin
    sclk = 1'b0;
    cs_b = 1'b1;
    si = 1'b0;
  end

  // ==========================================================
  // one frame of n bits, taken msb first from the top of b
  task automatic frame(input logic [39:0] b, input int n, output logic [7:0] q);
    q = 8'h00;
    cs_b = 1'b0;
    // setup gap after select, more than three system clocks
    #40;
    for (int i = 0; i < n; i++)
    begin
      si = b[39 - i];
      #32;
      // an undriven output line is read as garbage, not as data
      if (i >= 8)
        q = {q[6:0], so_oe_b ? ~so : so};
      sclk = 1'b1;
      #32;
      sclk = 1'b0;
    end
    #32;
    cs_b = 1'b1;
    // released line moves away from the last bit
    si = ~si;
    // deselect gap and time for the frame to be acted on
    #80;
  endtask

endmodule

/* serial_flash_status_regs_tb.sv */
// self-checking bench for the flash status register bank
`timescale 1ns/10ps

module serial_flash_status_regs_tb;

  // ==========================================================
  // design signals and bench state
  logic clk;
  logic rst_b;
  logic factory_b;
  logic wp_b;
  logic sclk;
  logic cs_b;
  logic si;
  logic so;
  logic so_oe_b;
  logic [1:0] drive_strength;
  logic hold_fn_active;
  logic reset_fn_active;
  logic wp_fn_active;
  logic four_wire_command_mode;
  logic write_busy;
  int n_mismatch = 0;
  int total_checks = 0;
  logic [7:0] q;
  logic [7:0] d;
  logic [7:0] h;
  logic [7:0] lk;
  // protection cases: low byte, mid byte, erase address, erase expected to start
  logic [40:0] pcase [9] = '{
    {8'h04, 8'h00, 24'hff0000, 1'b0},
    {8'h04, 8'h00, 24'hfb0000, 1'b1},
    {8'h24, 8'h00, 24'h000000, 1'b0},
    {8'h24, 8'h00, 24'hff0000, 1'b1},
    {8'h44, 8'h00, 24'hfff000, 1'b0},
    {8'h44, 8'h00, 24'hffe000, 1'b1},
    {8'h04, 8'h40, 24'hff0000, 1'b1},
    {8'h04, 8'h40, 24'h000000, 1'b0},
    {8'h00, 8'h00, 24'h000000, 1'b1}};

  // ==========================================================
  // design and far-side host
  serial_flash_status_regs dut (.clk(clk), .rst_b(rst_b), .factory_b(factory_b),
    .sclk(sclk), .cs_b(cs_b), .si(si), .so(so), .so_oe_b(so_oe_b), .wp_b(wp_b),
    .drive_strength(drive_strength), .hold_fn_active(hold_fn_active),
    .reset_fn_active(reset_fn_active), .wp_fn_active(wp_fn_active),
    .four_wire_command_mode(four_wire_command_mode), .write_busy(write_busy));

  flash_host_model host (.sclk(sclk), .cs_b(cs_b), .si(si), .so(so), .so_oe_b(so_oe_b));

  // ==========================================================
  // system clock and watchdog
  initial
  begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end

  initial
  begin
    #400000;
    n_mismatch++;
    summarize();
  end

  // ==========================================================
  // shared tasks
  task automatic chk(input string nm, input logic [7:0] seen, input logic [7:0] exp);
    total_checks++;
    if (seen !== exp)
    begin
      n_mismatch++;
      $display("[ERR] %s expected %h seen %h", nm, exp, seen);
    end
  endtask

  task automatic summarize();
    $display("checks %0d mismatches %0d", total_checks, n_mismatch);
    if (n_mismatch == 0 && total_checks > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask

  task automatic xfer(input logic [39:0] b, input int n);
    @(negedge clk);
    host.frame(b, n, q);
  endtask

  task automatic wait_idle();
    int i;
    i = 0;
    @(negedge clk);
    while (write_busy !== 1'b0 && i < 1000)
    begin
      @(negedge clk);
      i++;
    end
    chk("idle", {7'h00, write_busy}, 8'h00);
  endtask

  task automatic wr(input logic [7:0] op, input logic [7:0] dat);
    xfer({8'h06, 32'h0}, 8);
    xfer({op, dat, 24'h0}, 16);
    wait_idle();
  endtask

  task automatic rd(input logic [7:0] op, input logic [7:0] exp, input string nm);
    xfer({op, 32'h0}, 16);
    chk(nm, q, exp);
  endtask

  task automatic erase(input logic [23:0] a, input logic e);
    xfer({8'h06, 32'h0}, 8);
    xfer({8'h20, a, 8'h00}, 32);
    chk("erase_start", {7'h00, write_busy}, {7'h00, e});
    wait_idle();
  endtask

  // ==========================================================
  // main sequence
  initial
  begin
    rst_b = 1'b0;
    factory_b = 1'b0;
    wp_b = 1'b1;
    void'($urandom(69));
    repeat (6) @(negedge clk);
    chk("drive_rst", {6'h00, drive_strength}, 8'h02);
    rst_b = 1'b1;
    factory_b = 1'b1;
    repeat (4) @(negedge clk);
    rd(8'h05, 8'h00, "low_rst");
    rd(8'h35, 8'h00, "mid_rst");
    rd(8'h15, 8'h40, "high_rst");
    chk("fn_rst", {5'h00, wp_fn_active, hold_fn_active, reset_fn_active}, 8'h06);
    // write without the latch is dropped
    xfer({8'h01, 8'hfc, 24'h0}, 16);
    chk("busy_nolatch", {7'h00, write_busy}, 8'h00);
    rd(8'h05, 8'h00, "low_nolatch");
    // accepted write, status read while it runs, read-only bits ignored
    d = 8'($urandom) & 8'h7c;
    xfer({8'h06, 32'h0}, 8);
    rd(8'h05, 8'h02, "low_latch");
    xfer({8'h01, d | 8'h03, 24'h0}, 16);
    rd(8'h05, d | 8'h03, "low_busy");
    wait_idle();
    rd(8'h05, d, "low_done");
    // array protection geometry
    for (int k = 0; k < 9; k++)
    begin
      wr(8'h01, pcase[k][40:33]);
      wr(8'h31, pcase[k][32:25]);
      erase(pcase[k][24:1], pcase[k][0]);
    end
    // erase suspend and resume
    xfer({8'h06, 32'h0}, 8);
    xfer({8'h20, 32'h0}, 32);
    xfer({8'h75, 32'h0}, 8);
    chk("busy_paused", {7'h00, write_busy}, 8'h00);
    rd(8'h35, 8'h80, "mid_paused");
    xfer({8'h7a, 32'h0}, 8);
    chk("busy_resumed", {7'h00, write_busy}, 8'h01);
    wait_idle();
    rd(8'h35, 8'h00, "mid_resumed");
    // quad enable and four-wire mode
    xfer({8'h38, 32'h0}, 8);
    chk("fw_noquad", {7'h00, four_wire_command_mode}, 8'h00);
    wr(8'h31, 8'h02); // guard pin is driven, not tied, so quad may be set
    chk("fn_quad", {5'h00, wp_fn_active, hold_fn_active, reset_fn_active}, 8'h00);
    xfer({8'h38, 32'h0}, 8);
    chk("fw_on", {7'h00, four_wire_command_mode}, 8'h01);
    wr(8'h31, 8'h00);
    rd(8'h35, 8'h02, "mid_fw");
    xfer({8'hff, 32'h0}, 8);
    chk("fw_off", {7'h00, four_wire_command_mode}, 8'h00);
    wr(8'h31, 8'h00);
    rd(8'h35, 8'h00, "mid_noquad");
    // one-time lock bits
    lk = (8'($urandom) & 8'h3c) | 8'h04;
    wr(8'h31, lk);
    wr(8'h31, 8'h00);
    rd(8'h35, lk, "mid_lock");
    // highest register: pin function, drive, scheme select
    h = (8'($urandom) & 8'he0) | 8'h04;
    wr(8'h11, h | 8'h1b);
    rd(8'h15, h, "high_wr");
    chk("drive", {6'h00, drive_strength}, {6'h00, h[6:5]});
    chk("fn_sel", {6'h00, hold_fn_active, reset_fn_active}, {6'h00, ~h[7], h[7]});
    erase(24'h000000, 1'b0);
    // guard pin mode
    wr(8'h01, 8'h80);
    wp_b = 1'b0;
    wr(8'h01, 8'h04);
    rd(8'h05, 8'h82, "low_wp_lo");
    wp_b = 1'b1;
    wr(8'h01, 8'h00);
    rd(8'h05, 8'h00, "low_wp_hi");
    // supply lock-down, then a power cycle
    wr(8'h31, lk | 8'h01);
    wr(8'h01, 8'h04);
    rd(8'h05, 8'h02, "low_lockdown");
    @(negedge clk);
    rst_b = 1'b0;
    repeat (3) @(negedge clk);
    rst_b = 1'b1;
    repeat (4) @(negedge clk);
    rd(8'h35, lk, "mid_pwr");
    rd(8'h15, h, "high_pwr");
    rd(8'h05, 8'h00, "low_pwr");
    chk("oe_idle", {7'h00, so_oe_b}, 8'h01);
    summarize();
  end

endmodule
